//--- design/i2c_irq_enable_set.sv
// Interrupt enable mask and force-set registers of the I2C block
// Function
// [RQ1] Interrupt output asserts only for pending status sources whose enable bit is one.
// [RQ2] Enable bits sit at their status source positions: 6,7,14,15,20-24,27-31. SOURCE_MASK leaves out bit 24.
// [RQ3] Both registers reached only by internal register bus, never by serial slave path.
// [RQ4] Writing one to force-set sets that status; writing zero changes nothing.
// [RQ5] Forcing a bit sets all its underlying new events, not the summary directly.
// [RQ6] If all underlying events of a bit are disabled, forcing shows no change.
// [RQ7] Force-set covers all sources incl. bus-grant timeout at bit 30. SOURCE_MASK drops a force of bit 24.
// [RQ8] Software reads status snapshot before write-one-to-clear of its bits.
// [RQ9] A failed boot load end also sets collision, timeout and not-acknowledged statuses.
// [RQ10] Reserved bits read zero and ignore writes.
`timescale 1ns/1ps
`default_nettype none
module i2c_irq_enable_set
  import i2c_irq_pkg::*;
#(
  parameter int ADDR_W = ADDR_WIDTH,
  parameter int DATA_W = DATA_WIDTH
) (
  // Clock and reset
  input  wire logic              clk_i,
  input  wire logic              reset_i,
  // Internal register bus
  input  wire logic              reg_wr_i,
  input  wire logic              reg_rd_i,
  input  wire logic [ADDR_W-1:0] reg_addr_i,
  input  wire logic [DATA_W-1:0] reg_wdata_i,
  output logic      [DATA_W-1:0] reg_rdata_o,
  // Status from the interrupt status register and boot loader
  input  wire logic [DATA_W-1:0] irq_status_i,
  input  wire logic              bootload_fail_end_i,
  // Event set pulses and interrupt line
  output logic      [DATA_W-1:0] event_set_o,
  output logic                   irq_o
);

  // Register offsets at the bus address width
  localparam logic [ADDR_W-1:0] ENABLE_ADDR = ADDR_W'(ENABLE_MASK_OFFSET);
  localparam logic [ADDR_W-1:0] FORCE_ADDR  = ADDR_W'(FORCE_SET_OFFSET);

  // Source positions fix the word width; the offsets need the full address width
  if (DATA_W != DATA_WIDTH) begin : gen_bad_data_width
    $error("DATA_W must equal the 32-bit register word");
  end
  if (ADDR_W < ADDR_WIDTH) begin : gen_bad_addr_width
    $error("ADDR_W too narrow for the register offsets");
  end

  // Exact match of a bus address against one register offset
  function automatic logic addr_hits(input logic [ADDR_W-1:0] addr, input logic [ADDR_W-1:0] offset);
    return addr == offset;
  endfunction : addr_hits

  // Registers, next values and helpers
  logic      [DATA_W-1:0] enable_reg, enable_next;
  logic      [DATA_W-1:0] rdata_reg, rdata_next;
  logic      [DATA_W-1:0] event_set_reg, event_set_next;
  logic                   irq_reg, irq_next;
  logic      [DATA_W-1:0] force_bits;
  logic      [DATA_W-1:0] fanout;
  wire logic [DATA_W-1:0] pending;
  logic                   wr_enable_hit;
  logic                   wr_force_hit;
  logic                   rd_enable_hit;
  logic                   rd_force_hit;

  // Register bus decode; no other path reaches the two registers
  assign wr_enable_hit = reg_wr_i && addr_hits(reg_addr_i, ENABLE_ADDR); // RQ3
  assign wr_force_hit  = reg_wr_i && addr_hits(reg_addr_i, FORCE_ADDR);  // RQ3
  assign rd_enable_hit = reg_rd_i && addr_hits(reg_addr_i, ENABLE_ADDR); // RQ3
  assign rd_force_hit  = reg_rd_i && addr_hits(reg_addr_i, FORCE_ADDR);  // RQ3

  // Force bits written this cycle, reserved bits dropped
  always_comb begin
    force_bits = '0;
    if (wr_force_hit) begin
      force_bits = reg_wdata_i & SOURCE_MASK; // RQ4 RQ7 RQ10
    end
  end

  // Fan-out to the event lines
  i2c_irq_event_set #(
    .WIDTH (DATA_W)
  ) i2c_irq_event_set_i (
    .force_bits_i        (force_bits),
    .bootload_fail_end_i (bootload_fail_end_i),
    .event_set_o         (fanout)
  );

  // Per-source gating of pending status by its own enable bit
  for (genvar b = 0; b < DATA_W; b++) begin : gen_gate
    assign pending[b] = irq_status_i[b] & enable_reg[b] & SOURCE_MASK[b]; // RQ1 RQ2
  end

  // Next values of registers and outputs
  always_comb begin
    enable_next    = enable_reg;
    rdata_next     = rdata_reg;
    if (wr_enable_hit) begin
      enable_next = reg_wdata_i & SOURCE_MASK; // RQ2 RQ10
    end
    if (reg_rd_i) begin
      rdata_next = '0; // Unmapped reads return zero
      if (rd_enable_hit) begin
        rdata_next = enable_reg;
      end
      if (rd_force_hit) begin
        rdata_next = FORCE_SET_RESET; // RQ10
      end
    end
    event_set_next = fanout; // RQ5 RQ6 RQ9
    irq_next       = |pending; // RQ1
  end

  // Register stage
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      enable_reg    <= ENABLE_MASK_RESET;
      rdata_reg     <= '0;
      event_set_reg <= '0;
      irq_reg       <= 1'b0;
    end else begin
      enable_reg    <= enable_next;
      rdata_reg     <= rdata_next;
      event_set_reg <= event_set_next;
      irq_reg       <= irq_next;
    end
  end

  // Outputs straight from their flip-flops
  assign reg_rdata_o = rdata_reg;
  assign event_set_o = event_set_reg;
  assign irq_o       = irq_reg;

  // Request shapes on the register bus and from the boot loader
  sequence enable_write_s;
    reg_wr_i && reg_addr_i == ENABLE_ADDR;
  endsequence

  sequence force_write_s;
    reg_wr_i && reg_addr_i == FORCE_ADDR;
  endsequence

  sequence enable_read_s;
    reg_rd_i && reg_addr_i == ENABLE_ADDR;
  endsequence

  sequence force_read_s;
    reg_rd_i && reg_addr_i == FORCE_ADDR;
  endsequence

  sequence bootfail_end_s;
    bootload_fail_end_i;
  endsequence

  // Interrupt follows masked status one cycle later
  AST_IRQ_MASKED: assert property (@(posedge clk_i) disable iff (reset_i) // RQ1
    irq_o == $past(|(irq_status_i & enable_reg))) else $error("irq not masked status");

  // No interrupt the cycle after every source was masked
  AST_IRQ_ALL_MASKED: assert property (@(posedge clk_i) disable iff (reset_i) // RQ1
    enable_reg == '0 |=> !irq_o) else $error("irq with all sources masked");

  // A pending enabled source raises the interrupt next cycle
  AST_IRQ_RAISED: assert property (@(posedge clk_i) disable iff (reset_i) // RQ1
    (irq_status_i & enable_reg) != '0 |=> irq_o) else $error("irq missing for enabled source");

  // Reserved enable bits stay zero
  AST_ENABLE_RESERVED: assert property (@(posedge clk_i) disable iff (reset_i) // RQ10
    (enable_reg & ~SOURCE_MASK) == '0) else $error("reserved enable bit set");

  // Enable write lands at same positions
  AST_ENABLE_WRITE: assert property (@(posedge clk_i) disable iff (reset_i) // RQ2
    enable_write_s |=> enable_reg == ($past(reg_wdata_i) & SOURCE_MASK))
    else $error("enable write wrong");

  // Enable mask moves only on its own write
  AST_ENABLE_HOLD: assert property (@(posedge clk_i) disable iff (reset_i) // RQ3
    !(reg_wr_i && reg_addr_i == ENABLE_ADDR) |=> $stable(enable_reg))
    else $error("enable changed without write");

  // Enable read returns the mask held at the read edge
  AST_ENABLE_READ: assert property (@(posedge clk_i) disable iff (reset_i) // RQ2
    enable_read_s |=> reg_rdata_o == $past(enable_reg)) else $error("enable read wrong");

  // Unmapped reads return zero
  AST_UNMAPPED_READ: assert property (@(posedge clk_i) disable iff (reset_i) // RQ3
    reg_rd_i && reg_addr_i != ENABLE_ADDR && reg_addr_i != FORCE_ADDR |=> reg_rdata_o == '0)
    else $error("unmapped read nonzero");

  // Read data holds between reads
  AST_RDATA_HOLD: assert property (@(posedge clk_i) disable iff (reset_i) // RQ3
    !reg_rd_i |=> $stable(reg_rdata_o)) else $error("read data moved without read");

  // Force bit one pulses event set next cycle
  AST_FORCE_SET: assert property (@(posedge clk_i) disable iff (reset_i) // RQ4
    force_write_s |=> ((event_set_o & SOURCE_MASK & $past(reg_wdata_i))
    == (SOURCE_MASK & $past(reg_wdata_i)))) else $error("force missed");

  // Forced word reaches exactly its implemented bits
  AST_FORCE_EXACT: assert property (@(posedge clk_i) disable iff (reset_i) // RQ5
    force_write_s ##0 !bootload_fail_end_i |=> event_set_o == ($past(reg_wdata_i) & SOURCE_MASK))
    else $error("force word not exact");

  // Zeros written to force-set change nothing
  AST_FORCE_ZERO: assert property (@(posedge clk_i) disable iff (reset_i) // RQ4
    force_write_s ##0 ((reg_wdata_i & SOURCE_MASK) == '0) ##0 !bootload_fail_end_i |=> event_set_o == '0)
    else $error("zero force set an event");

  // Bit 30 forces bus-grant timeout
  AST_FORCE_BIT30: assert property (@(posedge clk_i) disable iff (reset_i) // RQ7
    force_write_s ##0 reg_wdata_i[CONTROLLER_BUS_GRANT_TIMEOUT_BIT]
    |=> event_set_o[CONTROLLER_BUS_GRANT_TIMEOUT_BIT]) else $error("bit 30 not forced");

  // No stray event set without cause
  AST_NO_STRAY: assert property (@(posedge clk_i) disable iff (reset_i) // RQ5
    !(reg_wr_i && reg_addr_i == FORCE_ADDR) && !bootload_fail_end_i |=> event_set_o == '0)
    else $error("stray event set");

  // Reserved positions never pulse
  AST_EVENT_RESERVED: assert property (@(posedge clk_i) disable iff (reset_i) // RQ10
    (event_set_o & ~SOURCE_MASK) == '0) else $error("reserved event pulsed");

  // Failed boot load end sets three controller statuses
  AST_BOOTFAIL: assert property (@(posedge clk_i) disable iff (reset_i) // RQ9
    bootfail_end_s |=> (event_set_o & BOOTLOAD_FAIL_SET_MASK) == BOOTLOAD_FAIL_SET_MASK)
    else $error("boot fail set missing");

  // Force register reads zero
  AST_FORCE_READ: assert property (@(posedge clk_i) disable iff (reset_i) // RQ10
    force_read_s |=> reg_rdata_o == '0) else $error("force read nonzero");

endmodule : i2c_irq_enable_set
`default_nettype wire

//--- design/i2c_irq_event_set.sv
// Per-source fan-out of forced bits onto the underlying event lines
`timescale 1ns/1ps
`default_nettype none
module i2c_irq_event_set
  import i2c_irq_pkg::*;
#(
  parameter int WIDTH = 32
) (
  // Forced bits and boot-load failure end
  input  wire logic [WIDTH-1:0] force_bits_i,
  input  wire logic             bootload_fail_end_i,
  // Per-source set request toward the new-event register
  output logic      [WIDTH-1:0] event_set_o
);
  // Source positions reach bit 31, so the word width is fixed
  if (WIDTH != DATA_WIDTH) begin : gen_bad_width
    $error("WIDTH must equal the 32-bit register word");
  end

  // Each forced bit except bit 24 sets every event of its source; failure end sets three controller statuses
  always_comb begin
    event_set_o = (force_bits_i & SOURCE_MASK[WIDTH-1:0])
                | (bootload_fail_end_i ? BOOTLOAD_FAIL_SET_MASK[WIDTH-1:0] : '0);
  end
endmodule : i2c_irq_event_set
`default_nettype wire

//--- design/i2c_irq_pkg.sv
// Package with offsets, bit positions and reset values of the I2C interrupt gating block
`default_nettype none
package i2c_irq_pkg;
  // Register byte offsets on the internal register bus
  localparam logic [16:0] ENABLE_MASK_OFFSET = 17'h1D120;
  localparam logic [16:0] FORCE_SET_OFFSET   = 17'h1D124;
  localparam int          ADDR_WIDTH         = 17;
  localparam int          DATA_WIDTH         = 32;
  // Reset values
  localparam logic [31:0] ENABLE_MASK_RESET  = 32'h0000_0000;
  localparam logic [31:0] FORCE_SET_RESET    = 32'h0000_0000;
  // Source bit positions
  localparam int OUTBOUND_MAILBOX_DRAINED_BIT      = 6;
  localparam int INBOUND_MAILBOX_LOADED_BIT        = 7;
  localparam int BOOTLOAD_FAILED_BIT               = 14;
  localparam int BOOTLOAD_SUCCEEDED_BIT            = 15;
  localparam int TARGET_ACCESS_FAILED_BIT          = 20;
  localparam int TARGET_REGISTER_WRITTEN_BIT       = 21;
  localparam int TARGET_REGISTER_READ_BIT          = 22;
  localparam int TARGET_ACCESS_SUCCEEDED_BIT       = 23;
  localparam int CONTROLLER_DIAGNOSTIC_EVENT_BIT   = 24;
  localparam int CONTROLLER_ARBITRATION_LOST_BIT   = 27;
  localparam int CONTROLLER_TIMEOUT_BIT            = 28;
  localparam int CONTROLLER_NOT_ACKNOWLEDGED_BIT   = 29;
  localparam int CONTROLLER_BUS_GRANT_TIMEOUT_BIT  = 30;
  localparam int CONTROLLER_TRANSFER_SUCCEEDED_BIT = 31;
  // Implemented bits, all others reserved
  localparam logic [31:0] SOURCE_MASK = 32'hF8F0_C0C0;
  // Statuses also set when a boot load ends in failure
  localparam logic [31:0] BOOTLOAD_FAIL_SET_MASK = 32'h3800_0000;
endpackage : i2c_irq_pkg
`default_nettype wire

//--- dv/i2c_interrupt_enable_set_bench.sv
// Bench for mask and force-set registers
`timescale 1ns/1ps
`default_nettype none
module i2c_interrupt_enable_set_bench;
  import i2c_irq_pkg::*;
  logic        clk_i = 0, reset_i = 1, reg_wr_i = 0, reg_rd_i = 0, boot_i = 0, irq_o;
  logic [16:0] reg_addr_i = '0;
  logic [31:0] reg_wdata_i = '0, clr = '0, status, event_set_o, reg_rdata_o, mask, v;
  int          miscompares = 0, n_checks = 0, seed = 82;
  // Clock
  initial forever #12.5 clk_i = ~clk_i;
  i2c_irq_enable_set i2c_irq_enable_set_i (.clk_i(clk_i), .reset_i(reset_i), .reg_wr_i(reg_wr_i),
    .reg_rd_i(reg_rd_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
    .irq_status_i(status), .bootload_fail_end_i(boot_i), .event_set_o(event_set_o), .irq_o(irq_o));
  i2c_irq_status_model i2c_irq_status_model_i (.clk_i(clk_i), .reset_i(reset_i),
    .event_set_i(event_set_o), .clear_i(clr), .status_o(status));
  // Compare and count
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  // Write, pulse outputs settled on return
  task automatic wr(input logic [16:0] a, input logic [31:0] d);
    @(posedge clk_i);
    reg_wr_i    <= 1'h1;
    reg_addr_i  <= a;
    reg_wdata_i <= d;
    @(posedge clk_i);
    reg_wr_i    <= 1'h0;
    reg_wdata_i <= ~d;
    #1;
  endtask : wr
  // Read and compare
  task automatic rd(input logic [16:0] a, input logic [31:0] exp);
    @(posedge clk_i);
    reg_rd_i   <= 1'h1;
    reg_addr_i <= a;
    @(posedge clk_i);
    reg_rd_i   <= 1'h0;
    #1;
    check(reg_rdata_o, exp);
  endtask : rd
  // Implemented bits only
  function automatic logic [31:0] legal(input logic [31:0] d);
    return d & SOURCE_MASK;
  endfunction : legal
  // Verdict
  task automatic finish_test();
    $display("checks=%0d miscompares=%0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : finish_test
  // Watchdog
  initial begin
    #200000;
    miscompares++;
    finish_test();
  end
  // Main sequence
  initial begin
    repeat (16) @(posedge clk_i);
    reset_i <= 1'h0;
    rd(ENABLE_MASK_OFFSET, ENABLE_MASK_RESET);
    for (int i = 0; i < 60; i++) begin
      v = (i == 0) ? 32'hFFFF_FFFF : (i == 1) ? 32'h0 : $random(seed);
      mask = legal(v);
      wr(ENABLE_MASK_OFFSET, v);
      rd(ENABLE_MASK_OFFSET, mask);
      v = $random(seed);
      wr(FORCE_SET_OFFSET, v);
      check(event_set_o, legal(v));
      rd(FORCE_SET_OFFSET, 32'h0);
      check({31'h0, irq_o}, {31'h0, |(status & mask)});
      clr <= status & $random(seed);
      @(posedge clk_i);
      clr <= 32'h0;
    end
    wr(FORCE_SET_OFFSET, 32'h0);
    check(event_set_o, 32'h0);
    wr(FORCE_SET_OFFSET, 32'h4000_0000);
    check(event_set_o, 32'h4000_0000);
    wr(17'h1D128, 32'hFFFF_FFFF);
    rd(17'h1D128, 32'h0);
    rd(ENABLE_MASK_OFFSET, mask);
    @(posedge clk_i);
    boot_i <= 1'h1;
    @(posedge clk_i);
    boot_i <= 1'h0;
    #1;
    check(event_set_o, BOOTLOAD_FAIL_SET_MASK);
    finish_test();
  end
endmodule : i2c_interrupt_enable_set_bench
`default_nettype wire

//--- dv/i2c_irq_status_model.sv
// Status register model fed by event pulses
`timescale 1ns/1ps
`default_nettype none
module i2c_irq_status_model (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        reset_i,
  // Events and software clear
  input  wire logic [31:0] event_set_i,
  input  wire logic [31:0] clear_i,
  // Status
  output logic      [31:0] status_o
);
  // Events set status, clear after snapshot
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) status_o <= 32'h0;
    else status_o <= (status_o | event_set_i) & ~clear_i;
  end
endmodule : i2c_irq_status_model
`default_nettype wire
